// file: core/mnx_exec.sv
// Four-phase execution datapath for literal/file multiply, file negate and no-op.
`timescale 1ns/1ps
module mnx_exec
    import mnx_pkg::*;
(
    // Clock, reset, enable
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_ce,
    // Instruction from the decoder
    input  wire logic              i_instr_valid,
    input  wire logic [15:0]       i_instr,
    output logic                   o_instr_ready,
    output logic                   o_done,
    output logic                   o_not_handled,
    // Core context
    input  wire logic [7:0]        i_working_reg,
    input  wire logic [3:0]        i_bank_select_reg,
    input  wire logic [ADDR_W-1:0] i_index_base,
    input  wire logic              i_ext_set_en,
    // Data memory
    output logic [ADDR_W-1:0]      o_mem_addr,
    output logic                   o_mem_rd,
    input  wire logic [7:0]        i_mem_rdata,
    output logic                   o_mem_wr,
    output logic [7:0]             o_mem_wdata,
    // Product pair and status flags
    output logic [7:0]             o_product_high_byte,
    output logic [7:0]             o_product_low_byte,
    output logic [4:0]             o_flags,
    output logic                   o_flags_wr
);
    mnx_phase_e        phase_ff,    nxt_phase;
    mnx_op_e           op_ff,       nxt_op;
    logic [15:0]       instr_ff,    nxt_instr;
    logic [ADDR_W-1:0] addr_ff,     nxt_addr;
    logic [7:0]        operand_ff,  nxt_operand;
    logic [7:0]        result_ff,   nxt_result;
    logic [15:0]       product_ff,  nxt_product;
    logic [7:0]        prod_hi_ff,  nxt_prod_hi;
    logic [7:0]        prod_lo_ff,  nxt_prod_lo;
    logic [4:0]        flags_ff,    nxt_flags;
    logic [4:0]        flagv_ff,    nxt_flagv;
    logic              mem_wr_ff,   nxt_mem_wr;
    logic              flags_wr_ff, nxt_flags_wr;
    logic              done_ff,     nxt_done;
    logic              other_ff,    nxt_other;
    logic [ADDR_W-1:0] resolved_addr;
    mnx_op_e           in_op;
    logic [7:0]        neg_val;

    assign in_op = mnx_decode(i_instr);

    mnx_addr_resolve u_addr (
        .i_file_addr       (i_instr[7:0]),
        .i_bank_bit        (i_instr[BANK_BIT_POS]),
        .i_ext_set_en      (i_ext_set_en),
        .i_bank_select_reg (i_bank_select_reg),
        .i_index_base      (i_index_base),
        .o_addr            (resolved_addr)
    );

    // The read strobe and ready are combinational so that a read fits in one phase.
    assign o_instr_ready = (phase_ff == MNX_PH_DECODE);
    assign o_mem_rd      = (phase_ff == MNX_PH_READ) &&
                           (op_ff == MNX_OP_FILE_MUL || op_ff == MNX_OP_FILE_NEG);
    assign neg_val       = 8'h00 - operand_ff;

    // Flags of a negation, worked out from the operand before it is negated.
    function automatic logic [4:0] mnx_neg_flags(input logic [7:0] operand);
        logic [7:0] res;
        logic [4:0] f;
        res        = 8'h00 - operand;
        f          = FLAGS_RST;
        f[FLAG_N]  = res[7];
        f[FLAG_Z]  = (res == 8'h00);
        f[FLAG_C]  = (operand == 8'h00);
        f[FLAG_DC] = (operand[3:0] == 4'h0);
        f[FLAG_OV] = (operand == 8'h80);
        return f;
    endfunction : mnx_neg_flags

    // Sequencing group: one phase per clock, every pulse raised for one cycle only.
    always_comb begin
        nxt_phase    = phase_ff;
        nxt_op       = op_ff;
        nxt_instr    = instr_ff;
        nxt_addr     = addr_ff;
        nxt_mem_wr   = 1'b0;
        nxt_flags_wr = 1'b0;
        nxt_done     = 1'b0;
        nxt_other    = 1'b0;
        case (phase_ff)
            MNX_PH_DECODE: begin
                if (i_instr_valid) begin
                    nxt_instr = i_instr;
                    nxt_op    = in_op;
                    nxt_addr  = resolved_addr;
                    nxt_phase = MNX_PH_READ;
                end
            end
            MNX_PH_READ: begin
                nxt_phase = MNX_PH_PROCESS;
            end
            MNX_PH_PROCESS: begin
                nxt_mem_wr = (op_ff == MNX_OP_FILE_NEG);
                nxt_phase  = MNX_PH_WRITE;
            end
            MNX_PH_WRITE: begin
                nxt_flags_wr = (op_ff == MNX_OP_FILE_NEG);
                nxt_other    = (op_ff == MNX_OP_OTHER);
                nxt_done     = 1'b1;
                nxt_phase    = MNX_PH_DECODE;
            end
            default: begin
                nxt_phase = MNX_PH_DECODE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            phase_ff    <= MNX_PH_DECODE;
            op_ff       <= MNX_OP_NOP;
            instr_ff    <= INSTR_RST;
            addr_ff     <= ADDR_RST;
            mem_wr_ff   <= 1'b0;
            flags_wr_ff <= 1'b0;
            done_ff     <= 1'b0;
            other_ff    <= 1'b0;
        end else if (i_ce) begin
            phase_ff    <= nxt_phase;
            op_ff       <= nxt_op;
            instr_ff    <= nxt_instr;
            addr_ff     <= nxt_addr;
            mem_wr_ff   <= nxt_mem_wr;
            flags_wr_ff <= nxt_flags_wr;
            done_ff     <= nxt_done;
            other_ff    <= nxt_other;
        end
    end

    // Datapath group: operand capture in the read phase, arithmetic in the process phase.
    always_comb begin
        nxt_operand = operand_ff;
        nxt_result  = result_ff;
        nxt_product = product_ff;
        nxt_flagv   = flagv_ff;
        case (phase_ff)
            MNX_PH_READ: begin
                case (op_ff)
                    MNX_OP_LIT_MUL:  nxt_operand = instr_ff[7:0];
                    MNX_OP_FILE_MUL: nxt_operand = i_mem_rdata;
                    MNX_OP_FILE_NEG: nxt_operand = i_mem_rdata;
                    default:         nxt_operand = operand_ff;
                endcase
            end
            MNX_PH_PROCESS: begin
                // Unsigned 8x8 cannot overflow 16 bits, so no carry or zero is derived.
                nxt_product = {8'h00, i_working_reg} * {8'h00, operand_ff};
                nxt_result  = neg_val;
                nxt_flagv   = mnx_neg_flags(operand_ff);
            end
            default: begin
                nxt_operand = operand_ff;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            operand_ff <= PROD_RST;
            result_ff  <= PROD_RST;
            product_ff <= {PROD_RST, PROD_RST};
            flagv_ff   <= FLAGS_RST;
        end else if (i_ce) begin
            operand_ff <= nxt_operand;
            result_ff  <= nxt_result;
            product_ff <= nxt_product;
            flagv_ff   <= nxt_flagv;
        end
    end

    // Architectural group: the product pair and the flags change only in the write phase.
    always_comb begin
        nxt_prod_hi = prod_hi_ff;
        nxt_prod_lo = prod_lo_ff;
        nxt_flags   = flags_ff;
        if (phase_ff == MNX_PH_WRITE) begin
            case (op_ff)
                MNX_OP_LIT_MUL, MNX_OP_FILE_MUL: begin
                    // Flags, working register and memory stay untouched.
                    nxt_prod_hi = product_ff[15:8];
                    nxt_prod_lo = product_ff[7:0];
                end
                MNX_OP_FILE_NEG: begin
                    nxt_flags = flagv_ff;
                end
                default: begin
                    // No-op and unhandled words leave the pair and the flags alone.
                    nxt_prod_hi = prod_hi_ff;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            prod_hi_ff <= PROD_RST;
            prod_lo_ff <= PROD_RST;
            flags_ff   <= FLAGS_RST;
        end else if (i_ce) begin
            prod_hi_ff <= nxt_prod_hi;
            prod_lo_ff <= nxt_prod_lo;
            flags_ff   <= nxt_flags;
        end
    end

    // Pulses are gated by the enable so a frozen core never sees a repeated strobe.
    assign o_mem_addr          = addr_ff;
    assign o_mem_wdata         = result_ff;
    assign o_mem_wr            = mem_wr_ff && i_ce;
    assign o_flags_wr          = flags_wr_ff && i_ce;
    assign o_done              = done_ff && i_ce;
    assign o_not_handled       = other_ff && i_ce;
    assign o_product_high_byte = prod_hi_ff;
    assign o_product_low_byte  = prod_lo_ff;
    assign o_flags             = flags_ff;
endmodule : mnx_exec

// file: core/mnx_pkg.sv
// Constants, opcode layout and operation types for the multiply/negate/no-op datapath.
// How it works
// - Literal multiply: working register times immediate byte, unsigned, 16-bit product.
// - Product high byte and low byte go to their registers; working register untouched.
// - File multiply: working register times addressed data byte, unsigned, into product pair.
// - Multiplies leave working register, source byte and every status flag unchanged.
// - Multiplies report no overflow, no carry and no zero result.
// - Bank bit zero selects the access bank and ignores the bank select register.
// - Bank bit one takes upper address bits from the bank select register.
// - Bank bit zero, extended set on, address up to 95: indexed literal offset.
package mnx_pkg;
    localparam int          ADDR_W          = 12;
    // Opcode fields, compared against the whole word, the upper byte, the upper seven bits or the upper nibble.
    localparam logic [7:0]  OPC_LIT_MUL     = 8'h0D;
    localparam logic [6:0]  OPC_FILE_MUL    = 7'h01;
    localparam logic [6:0]  OPC_FILE_NEG    = 7'h36;
    localparam logic [15:0] OPC_NOP_ZERO    = 16'h0000;
    localparam logic [3:0]  OPC_NOP_NIBBLE  = 4'hF;
    localparam int          BANK_BIT_POS    = 8;
    // Indexed literal offset applies to file addresses at or below this value.
    localparam logic [7:0]  INDEX_LIMIT     = 8'h5F;
    // Access bank split: lower part maps to bank zero, upper part to the top bank.
    localparam logic [7:0]  ACCESS_SPLIT    = 8'h80;
    localparam logic [3:0]  ACCESS_HI_BANK  = 4'hF;
    localparam logic [3:0]  ACCESS_LO_BANK  = 4'h0;
    // Reset values.
    localparam logic [7:0]  PROD_RST        = 8'h00;
    localparam logic [4:0]  FLAGS_RST       = 5'h00;
    localparam logic [15:0] INSTR_RST       = 16'h0000;
    localparam logic [11:0] ADDR_RST        = 12'h000;
    // Flag vector bit positions.
    localparam int          FLAG_C          = 0;
    localparam int          FLAG_DC         = 1;
    localparam int          FLAG_Z          = 2;
    localparam int          FLAG_OV         = 3;
    localparam int          FLAG_N          = 4;
    // Clocks per instruction cycle, one per phase.
    localparam int          PHASES_PER_INSN = 4;

    typedef enum logic [2:0] {
        MNX_OP_NOP,
        MNX_OP_LIT_MUL,
        MNX_OP_FILE_MUL,
        MNX_OP_FILE_NEG,
        MNX_OP_OTHER
    } mnx_op_e;

    typedef enum logic [1:0] {
        MNX_PH_DECODE,
        MNX_PH_READ,
        MNX_PH_PROCESS,
        MNX_PH_WRITE
    } mnx_phase_e;

    // Opcode decoding used by the datapath only; the address path does not call it.
    function automatic mnx_op_e mnx_decode(input logic [15:0] instr);
        mnx_op_e op;
        op = MNX_OP_OTHER;
        if (instr == OPC_NOP_ZERO || instr[15:12] == OPC_NOP_NIBBLE) begin
            op = MNX_OP_NOP;
        end else if (instr[15:8] == OPC_LIT_MUL) begin
            op = MNX_OP_LIT_MUL;
        end else if (instr[15:9] == OPC_FILE_MUL) begin
            op = MNX_OP_FILE_MUL;
        end else if (instr[15:9] == OPC_FILE_NEG) begin
            op = MNX_OP_FILE_NEG;
        end
        return op;
    endfunction : mnx_decode
endpackage : mnx_pkg

// file: core/mnx_addr_resolve.sv
// Resolves an 8-bit file operand into a full data-memory address.
`timescale 1ns/1ps
module mnx_addr_resolve
    import mnx_pkg::*;
(
    // Operand
    input  wire logic [7:0]        i_file_addr,
    input  wire logic              i_bank_bit,
    // Addressing context
    input  wire logic              i_ext_set_en,
    input  wire logic [3:0]        i_bank_select_reg,
    input  wire logic [ADDR_W-1:0] i_index_base,
    // Result
    output logic      [ADDR_W-1:0] o_addr
);
    always_comb begin
        if (i_bank_bit) begin
            o_addr = {i_bank_select_reg, i_file_addr};
        end else if (i_ext_set_en && i_file_addr <= INDEX_LIMIT) begin
            // Wraps inside the data space rather than faulting.
            o_addr = i_index_base + {4'h0, i_file_addr};
        end else if (i_file_addr < ACCESS_SPLIT) begin
            o_addr = {ACCESS_LO_BANK, i_file_addr};
        end else begin
            o_addr = {ACCESS_HI_BANK, i_file_addr};
        end
    end
endmodule : mnx_addr_resolve

// file: tb/mnx_mem_model.sv
// Data memory model that answers the datapath's reads in the same cycle.
`timescale 1ns/1ps
module mnx_mem_model (
    // Clock
    input  wire logic        i_clk,
    // Access
    input  wire logic [11:0] i_addr,
    input  wire logic        i_rd,
    input  wire logic        i_wr,
    input  wire logic [7:0]  i_wdata,
    output logic      [7:0]  o_rdata
);
    logic [7:0] mem [4096];
    logic [7:0] last_ff = 8'h00;
    // The bank number enters the fill pattern, so a byte read from the wrong bank differs.
    initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i * 37 + (i >> 8) * 101 + 11);
    // A released bus shows the inverse of the last byte, so a late sample cannot match.
    assign o_rdata = i_rd ? mem[i_addr] : ~last_ff;
    always @(posedge i_clk) begin
        if (i_rd) last_ff <= mem[i_addr];
        if (i_wr) mem[i_addr] <= i_wdata;
    end
endmodule : mnx_mem_model

// file: tb/mnx_exec_props.sv
// Port-level checks of the execution datapath.
`timescale 1ns/1ps
module mnx_exec_props
    import mnx_pkg::*;
(
    // Clock and reset
    input wire logic              i_clk,
    input wire logic              i_rst_n,
    // Observed ports
    input wire logic              i_ce,
    input wire logic              i_instr_valid,
    input wire logic [15:0]       i_instr,
    input wire logic              o_instr_ready,
    input wire logic              o_done,
    input wire logic [7:0]        i_working_reg,
    input wire logic [3:0]        i_bank_select_reg,
    input wire logic [ADDR_W-1:0] i_index_base,
    input wire logic              i_ext_set_en,
    input wire logic [ADDR_W-1:0] o_mem_addr,
    input wire logic              o_mem_rd,
    input wire logic [7:0]        i_mem_rdata,
    input wire logic              o_mem_wr,
    input wire logic [7:0]        o_mem_wdata,
    input wire logic [7:0]        o_product_high_byte,
    input wire logic [7:0]        o_product_low_byte,
    input wire logic [4:0]        o_flags,
    input wire logic              o_flags_wr
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    logic              take, lit, fmul, neg, nop;
    logic [7:0]        neg_res;
    logic [4:0]        exp_flags;
    logic [ADDR_W-1:0] exp_addr;
    logic [15:0]       prod;
    assign take = i_ce && i_instr_valid && o_instr_ready;
    assign lit = i_instr[15:8] == OPC_LIT_MUL;
    assign fmul = i_instr[15:9] == OPC_FILE_MUL;
    assign neg = i_instr[15:9] == OPC_FILE_NEG;
    assign nop = i_instr == OPC_NOP_ZERO || i_instr[15:12] == OPC_NOP_NIBBLE;
    assign prod = {o_product_high_byte, o_product_low_byte};
    assign neg_res = 8'h00 - i_mem_rdata;
    assign exp_flags = {neg_res[7], i_mem_rdata == 8'h80, neg_res == 8'h00,
                        i_mem_rdata[3:0] == 4'h0, i_mem_rdata == 8'h00};
    always_comb begin
        if (i_instr[BANK_BIT_POS]) exp_addr = {i_bank_select_reg, i_instr[7:0]};
        else if (i_ext_set_en && i_instr[7:0] <= INDEX_LIMIT)
            exp_addr = i_index_base + 12'(i_instr[7:0]);
        else exp_addr = {(i_instr[7] ? ACCESS_HI_BANK : ACCESS_LO_BANK), i_instr[7:0]};
    end
    sequence s_busy;
        (!o_instr_ready) [*3] ##1 o_instr_ready;
    endsequence
    sequence s_read;
        o_mem_rd && o_mem_addr == $past(exp_addr);
    endsequence
    chk_done_latency: assert property (take |-> ##4 o_done)
        else $error("done not four clocks after take");
    chk_ready_busy: assert property (take |=> s_busy)
        else $error("ready wrong during instruction");
    chk_lit_product: assert property (take && lit |-> ##4
        prod == 16'($past(i_working_reg, 4)) * 16'($past(i_instr[7:0], 4)))
        else $error("literal product wrong");
    chk_file_product: assert property (take && fmul |-> ##1 s_read ##3
        prod == 16'($past(i_working_reg, 4)) * 16'($past(i_mem_rdata, 3)))
        else $error("file product wrong");
    chk_mul_quiet: assert property ((take && (lit || fmul)) |=>
        ($stable(o_flags) && !o_flags_wr && !o_mem_wr) [*4])
        else $error("multiply touched flags or memory");
    chk_file_addr: assert property (take && (fmul || neg) |=> s_read)
        else $error("file address wrong");
    chk_neg_write: assert property (take && neg |-> ##1 s_read ##2
        (o_mem_wr && o_mem_wdata == 8'(8'h00 - $past(i_mem_rdata, 2))))
        else $error("negate write wrong");
    chk_neg_flags: assert property (take && neg |-> ##1 s_read ##3
        (o_flags_wr && o_flags == $past(exp_flags, 3)))
        else $error("negate flags wrong");
    chk_nop_idle: assert property (take && nop |=>
        (!o_mem_rd && !o_mem_wr && !o_flags_wr && $stable(prod)) [*4])
        else $error("no-op had side effects");
endmodule : mnx_exec_props

bind mnx_exec mnx_exec_props u_mnx_exec_props (
    .i_clk               (i_clk),
    .i_rst_n             (i_rst_n),
    .i_ce                (i_ce),
    .i_instr_valid       (i_instr_valid),
    .i_instr             (i_instr),
    .o_instr_ready       (o_instr_ready),
    .o_done              (o_done),
    .i_working_reg       (i_working_reg),
    .i_bank_select_reg   (i_bank_select_reg),
    .i_index_base        (i_index_base),
    .i_ext_set_en        (i_ext_set_en),
    .o_mem_addr          (o_mem_addr),
    .o_mem_rd            (o_mem_rd),
    .i_mem_rdata         (i_mem_rdata),
    .o_mem_wr            (o_mem_wr),
    .o_mem_wdata         (o_mem_wdata),
    .o_product_high_byte (o_product_high_byte),
    .o_product_low_byte  (o_product_low_byte),
    .o_flags             (o_flags),
    .o_flags_wr          (o_flags_wr)
);

// file: tb/tb_top.sv
// Self-checking bench for the multiply/negate/no-op datapath.
`timescale 1ns/1ps
module tb_top;
    import mnx_pkg::*;
    logic              i_clk = 0, i_rst_n = 0, i_ce = 1, i_instr_valid = 0, i_ext_set_en = 0;
    logic [15:0]       i_instr = 16'h0000;
    logic [7:0]        i_working_reg = 8'h00;
    logic [3:0]        i_bank_select_reg = 4'h3;
    logic [ADDR_W-1:0] i_index_base = 12'h700;
    logic              o_instr_ready, o_done, o_not_handled, o_mem_rd, o_mem_wr, o_flags_wr;
    logic [ADDR_W-1:0] o_mem_addr;
    logic [7:0]        i_mem_rdata, o_mem_wdata, o_product_high_byte, o_product_low_byte;
    logic [4:0]        o_flags;
    int                fails = 0, checks = 0, cycles = 0;
    logic              got_nh = 1'b0;
    always #2 i_clk = ~i_clk;
    mnx_exec u_mnx_exec (
        .i_clk               (i_clk),
        .i_rst_n             (i_rst_n),
        .i_ce                (i_ce),
        .i_instr_valid       (i_instr_valid),
        .i_instr             (i_instr),
        .o_instr_ready       (o_instr_ready),
        .o_done              (o_done),
        .o_not_handled       (o_not_handled),
        .i_working_reg       (i_working_reg),
        .i_bank_select_reg   (i_bank_select_reg),
        .i_index_base        (i_index_base),
        .i_ext_set_en        (i_ext_set_en),
        .o_mem_addr          (o_mem_addr),
        .o_mem_rd            (o_mem_rd),
        .i_mem_rdata         (i_mem_rdata),
        .o_mem_wr            (o_mem_wr),
        .o_mem_wdata         (o_mem_wdata),
        .o_product_high_byte (o_product_high_byte),
        .o_product_low_byte  (o_product_low_byte),
        .o_flags             (o_flags),
        .o_flags_wr          (o_flags_wr)
    );
    mnx_mem_model u_mnx_mem_model (.i_clk(i_clk), .i_addr(o_mem_addr), .i_rd(o_mem_rd),
        .i_wr(o_mem_wr), .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
    task automatic stop_test();
        if (fails == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // Entered and left just after a rising edge; valid is held until the rising edge after ready is seen high.
    task automatic run(input logic [15:0] ins);
        int n = 0;
        i_instr_valid = 1;
        i_instr = ins;
        @(negedge i_clk);
        while (o_instr_ready !== 1'b1 && n < 20) begin @(negedge i_clk); n++; end
        @(posedge i_clk);
        #1 i_instr_valid = 0;
        n = 0;
        while (o_done !== 1'b1 && n < 20) begin @(negedge i_clk); n++; end
        got_nh = o_not_handled;
        cmp(16'(n), 16'(PHASES_PER_INSN));
        @(posedge i_clk);
        #1;
    endtask : run
    task automatic t_negate();
        logic [7:0] v[4] = '{8'h3A, 8'h00, 8'h80, 8'h01};
        logic [7:0] r;
        logic [4:0] ef;
        foreach (v[k]) begin
            u_mnx_mem_model.mem[12'h340] = v[k];
            r = 8'h00 - v[k];
            ef = {r[7], v[k] == 8'h80, r == 8'h00, v[k][3:0] == 4'h0, v[k] == 8'h00};
            run({OPC_FILE_NEG, 1'b1, 8'h40});
            cmp(16'(o_flags), 16'(ef));
            cmp(16'(u_mnx_mem_model.mem[12'h340]), 16'(r));
        end
    endtask : t_negate
    task automatic t_lit(input logic [7:0] w, input logic [7:0] k);
        logic [4:0] f0;
        f0 = o_flags;
        i_working_reg = w;
        run({OPC_LIT_MUL, k});
        cmp({o_product_high_byte, o_product_low_byte}, 16'(w) * 16'(k));
        cmp(16'(o_flags), 16'(f0));
    endtask : t_lit
    task automatic t_file(input logic a, input logic ext, input logic [7:0] f,
                          input logic [11:0] adr);
        logic [7:0] m;
        logic [4:0] f0;
        m = u_mnx_mem_model.mem[adr];
        f0 = o_flags;
        i_ext_set_en = ext;
        i_working_reg = 8'hC4;
        run({OPC_FILE_MUL, a, f});
        cmp({o_product_high_byte, o_product_low_byte}, 16'hC4 * 16'(m));
        cmp(16'(u_mnx_mem_model.mem[adr]), 16'(m));
        cmp(16'(o_flags), 16'(f0));
    endtask : t_file
    task automatic t_nop(input logic [15:0] ins, input logic exp_nh);
        logic [15:0] p;
        p = {o_product_high_byte, o_product_low_byte};
        i_working_reg = 8'h77;
        run(ins);
        cmp({o_product_high_byte, o_product_low_byte}, p);
        cmp(16'(got_nh), 16'(exp_nh));
    endtask : t_nop
    // With the enable low an offered word must not be taken and nothing may move.
    task automatic t_freeze();
        logic [15:0] p;
        p = {o_product_high_byte, o_product_low_byte};
        i_ce = 0;
        i_working_reg = 8'h3B;
        i_instr = {OPC_LIT_MUL, 8'h29};
        i_instr_valid = 1;
        repeat (6) @(posedge i_clk);
        #1;
        cmp({o_product_high_byte, o_product_low_byte}, p);
        cmp(16'(o_instr_ready), 16'd1);
        i_instr_valid = 0;
        i_ce = 1;
        @(posedge i_clk);
        #1;
    endtask : t_freeze
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            $display("mismatch %0t timeout", $time);
            stop_test();
        end
    end
    initial begin
        repeat (4) @(posedge i_clk);
        #1 i_rst_n = 1;
        t_negate();
        t_lit(8'hE2, 8'hC4);
        t_lit(8'hFF, 8'hFF);
        t_lit(8'h00, 8'h5A);
        t_freeze();
        t_file(1'b1, 1'b0, 8'h45, 12'h345);
        t_file(1'b1, 1'b1, 8'h20, 12'h320);
        t_file(1'b0, 1'b0, 8'h10, 12'h010);
        t_file(1'b0, 1'b0, 8'h90, 12'hF90);
        t_file(1'b0, 1'b1, 8'h5F, 12'h75F);
        t_file(1'b0, 1'b1, 8'h60, 12'h060);
        t_nop(16'h0000, 1'b0);
        t_nop(16'hF123, 1'b0);
        t_nop(16'h0E5A, 1'b1);
        stop_test();
    end
endmodule : tb_top
